// ### adc_seq.sv
/*
  converter init and capture sequencer with its serial shifter.
  writes enabled converter registers, then loops conversion commands per
  enabled channel, storing each 16-bit result in static memory, then
  grants the memory bus to the host. configuration arrives on plain ports
  and must be stable from reset until the bus grant rises.
*/
// Contract
// - write every enabled register, address then data
// - load byte into shifter, then request shift
// - size flag 0 sends one byte out
// - size flag 1 receives sixteen result bits
// - record register number, clear its enable flag
// - wait for shifter done after each send
// - recorded number picks data byte to send
// - flags left loop back, else start conversions
// - send channel command, set memory pointer
// - then size flag 1 and shift request
// - store received result at memory pointer
// - at limit next channel, else repeat, else finish
// - convert every enabled channel before ending
// - final state stops transfers, grants host bus
// - idle state sets control outputs to defaults
// - chip select high after every finished send except the channel command, which holds it low for the result
// - data changes while clock low, held high
`timescale 1ns/1ps
module adc_seq #(
  parameter int NUM_REGS = adc_seq_pkg::NUM_REGS_DEF,
  parameter int NUM_CHAN = adc_seq_pkg::NUM_CHAN_DEF,
  parameter int ADDR_W   = adc_seq_pkg::ADDR_W_DEF
) (
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  input  wire logic                       clk_en,
  input  wire logic [NUM_REGS-1:0]        cfg_reg_en,
  input  wire logic [NUM_REGS*8-1:0]      cfg_reg_data,
  input  wire logic [NUM_CHAN-1:0]        chan_en,
  input  wire logic [NUM_CHAN*8-1:0]      chan_cmd,
  input  wire logic [NUM_CHAN*ADDR_W-1:0] chan_base,
  input  wire logic [NUM_CHAN*ADDR_W-1:0] chan_high,
  input  wire logic                       adc_dout,
  output logic                            adc_sclk,
  output logic                            adc_din,
  output logic                            adc_cs_n,
  output logic [ADDR_W-1:0]               sram_addr,
  output logic [15:0]                     sram_data,
  output logic                            sram_we_n,
  output logic                            host_bus_grant
);
  import adc_seq_pkg::*;

  // the search helper works on 16-bit vectors with 4-bit indices
  if (NUM_REGS < 1 || NUM_REGS > 16) begin : g_bad_regs
    $error("NUM_REGS must be 1 to 16");
  end
  if (NUM_CHAN < 1 || NUM_CHAN > 15) begin : g_bad_chan
    $error("NUM_CHAN must be 1 to 15");
  end

  // lowest set bit at or above from; msb of result says one was found
  function automatic logic [4:0] first_from(input logic [15:0] v,
                                            input logic [4:0]  from);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (v[i] && (5'(i) >= from)) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // sequencer state
  seq_state_t          st_q, st_d;
  logic [NUM_REGS-1:0] flags_q, flags_d;
  logic [3:0]          reg_num_q, reg_num_d;
  logic [3:0]          chan_q, chan_d;
  logic                new_chan_q, new_chan_d;
  logic [ADDR_W-1:0]   addr_q, addr_d;
  logic [7:0]          tx_byte_q, tx_byte_d;
  logic                size_q, size_d;
  logic                go_q, go_d;
  logic                hold_cs_q, hold_cs_d;
  logic [15:0]         data_q, data_d;
  logic                we_n_q, we_n_d;
  logic                grant_q, grant_d;

  // shifter state
  sh_state_t           sh_q, sh_d;
  logic [7:0]          tm_q, tm_d;
  logic [4:0]          bits_q, bits_d;
  logic [15:0]         sreg_q, sreg_d;
  logic                sh_size_q, sh_size_d;
  logic                sh_hold_q, sh_hold_d;
  logic                sclk_q, sclk_d;
  logic                din_q, din_d;
  logic                cs_n_q, cs_n_d;
  logic                done_q, done_d;
  logic                dout_s1_q, dout_s2_q;

  logic [4:0]          pick;
  logic [ADDR_W-1:0]   high_sel;

  assign high_sel = chan_high[chan_q*ADDR_W +: ADDR_W];

  // sequencer next state and outputs
  always_comb begin
    st_d       = st_q;
    flags_d    = flags_q;
    reg_num_d  = reg_num_q;
    chan_d     = chan_q;
    new_chan_d = new_chan_q;
    addr_d     = addr_q;
    tx_byte_d  = tx_byte_q;
    size_d     = size_q;
    go_d       = 1'b0;
    hold_cs_d  = hold_cs_q;
    data_d     = data_q;
    we_n_d     = WE_N_IDLE;
    grant_d    = grant_q;
    pick       = 5'h00;
    case (st_q)
      ST_IDLE: begin
        // defaults, and the write flags reloaded from configuration
        size_d    = SIZE_BYTE_OUT;
        hold_cs_d = 1'b0;
        grant_d   = 1'b0;
        flags_d   = cfg_reg_en;
        if (|cfg_reg_en) begin
          st_d = ST_ADDR_SEND;
        end else begin
          pick = first_from(16'(chan_en), 5'h00);
          chan_d     = pick[3:0];
          new_chan_d = 1'b1;
          st_d = pick[4] ? ST_CMD_SEND : ST_FINISHED;
        end
      end
      ST_ADDR_SEND: begin
        pick      = first_from(16'(flags_q), 5'h00);
        reg_num_d = pick[3:0];
        flags_d   = flags_q & ~NUM_REGS'(1 << pick[3:0]);
        tx_byte_d = {4'h0, pick[3:0]};
        size_d    = SIZE_BYTE_OUT;
        hold_cs_d = 1'b0;
        go_d      = 1'b1;
        st_d      = ST_ADDR_WAIT;
      end
      ST_ADDR_WAIT: begin
        if (done_q) begin
          st_d = ST_DATA_SEND;
        end
      end
      ST_DATA_SEND: begin
        tx_byte_d = cfg_reg_data[reg_num_q*8 +: 8];
        go_d      = 1'b1;
        st_d      = ST_DATA_WAIT;
      end
      ST_DATA_WAIT: begin
        if (done_q) begin
          if (|flags_q) begin
            st_d = ST_ADDR_SEND;
          end else begin
            pick = first_from(16'(chan_en), 5'h00);
            chan_d     = pick[3:0];
            new_chan_d = 1'b1;
            st_d = pick[4] ? ST_CMD_SEND : ST_FINISHED;
          end
        end
      end
      ST_CMD_SEND: begin
        // first command of a channel starts at its base address
        addr_d     = new_chan_q ? chan_base[chan_q*ADDR_W +: ADDR_W]
                                : addr_q + ADDR_W'(1);
        new_chan_d = 1'b0;
        tx_byte_d  = chan_cmd[chan_q*8 +: 8];
        size_d     = SIZE_BYTE_OUT;
        hold_cs_d  = 1'b1;
        go_d       = 1'b1;
        st_d       = ST_CMD_WAIT;
      end
      ST_CMD_WAIT: begin
        if (done_q) begin
          st_d = ST_RX_START;
        end
      end
      ST_RX_START: begin
        size_d    = SIZE_WORD_IN;
        hold_cs_d = 1'b0;
        go_d      = 1'b1;
        st_d      = ST_RX_WAIT;
      end
      ST_RX_WAIT: begin
        if (done_q) begin
          data_d = sreg_q;
          we_n_d = 1'b0;
          if (addr_q == high_sel) begin
            pick = first_from(16'(chan_en), 5'(chan_q) + 5'h01);
            chan_d     = pick[3:0];
            new_chan_d = 1'b1;
            st_d = pick[4] ? ST_CMD_SEND : ST_FINISHED;
          end else begin
            st_d = ST_CMD_SEND;
          end
        end
      end
      ST_FINISHED: begin
        grant_d = 1'b1;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_q       <= ST_IDLE;
      flags_q    <= '0;
      reg_num_q  <= 4'h0;
      chan_q     <= 4'h0;
      new_chan_q <= 1'b0;
      addr_q     <= '0;
      tx_byte_q  <= 8'h00;
      size_q     <= SIZE_BYTE_OUT;
      go_q       <= 1'b0;
      hold_cs_q  <= 1'b0;
      data_q     <= 16'h0000;
      we_n_q     <= WE_N_IDLE;
      grant_q    <= 1'b0;
    end else if (clk_en) begin
      st_q       <= st_d;
      flags_q    <= flags_d;
      reg_num_q  <= reg_num_d;
      chan_q     <= chan_d;
      new_chan_q <= new_chan_d;
      addr_q     <= addr_d;
      tx_byte_q  <= tx_byte_d;
      size_q     <= size_d;
      go_q       <= go_d;
      hold_cs_q  <= hold_cs_d;
      data_q     <= data_d;
      we_n_q     <= we_n_d;
      grant_q    <= grant_d;
    end
  end

  // shifter: msb first, din changes only while sclk is low and
  // dout is sampled at the end of the high phase to absorb sync delay
  always_comb begin
    sh_d      = sh_q;
    tm_d      = tm_q;
    bits_d    = bits_q;
    sreg_d    = sreg_q;
    sh_size_d = sh_size_q;
    sh_hold_d = sh_hold_q;
    sclk_d    = sclk_q;
    din_d     = din_q;
    cs_n_d    = cs_n_q;
    done_d    = 1'b0;
    case (sh_q)
      SH_IDLE: begin
        if (go_q) begin
          sh_size_d = size_q;
          sh_hold_d = hold_cs_q;
          sreg_d    = {8'h00, tx_byte_q};
          bits_d    = (size_q == SIZE_WORD_IN) ? 5'(RX_BITS)
                                               : 5'(TX_BITS);
          din_d     = (size_q == SIZE_WORD_IN) ? 1'b0 : tx_byte_q[7];
          cs_n_d    = 1'b0;
          sclk_d    = 1'b0;
          tm_d      = 8'(SCLK_HALF_CYC - 1);
          sh_d      = SH_LOW;
        end
      end
      SH_LOW: begin
        if (tm_q == 8'h00) begin
          sclk_d = 1'b1;
          tm_d   = 8'(SCLK_HALF_CYC - 1);
          sh_d   = SH_HIGH;
        end else begin
          tm_d = tm_q - 8'h01;
        end
      end
      SH_HIGH: begin
        if (tm_q == 8'h00) begin
          sreg_d = {sreg_q[14:0], dout_s2_q};
          bits_d = bits_q - 5'h01;
          sclk_d = 1'b0;
          // next bit appears on the same edge that sclk falls
          din_d  = (sh_size_q == SIZE_WORD_IN) ? 1'b0 : sreg_q[6];
          if (bits_q == 5'h01) begin
            if (sh_hold_q) begin
              // keep cs low so the result follows the command
              done_d = 1'b1;
              sh_d   = SH_IDLE;
            end else begin
              cs_n_d = 1'b1;
              tm_d   = 8'(CS_GAP_CYC - 1);
              sh_d   = SH_GAP;
            end
          end else begin
            tm_d = 8'(SCLK_HALF_CYC - 1);
            sh_d = SH_LOW;
          end
        end else begin
          tm_d = tm_q - 8'h01;
        end
      end
      SH_GAP: begin
        if (tm_q == 8'h00) begin
          done_d = 1'b1;
          sh_d   = SH_IDLE;
        end else begin
          tm_d = tm_q - 8'h01;
        end
      end
      default: begin
        sh_d = SH_IDLE;
      end
    endcase
  end

  // shifter registers; dout passes two flip-flops before use
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sh_q      <= SH_IDLE;
      tm_q      <= 8'h00;
      bits_q    <= 5'h00;
      sreg_q    <= 16'h0000;
      sh_size_q <= SIZE_BYTE_OUT;
      sh_hold_q <= 1'b0;
      sclk_q    <= SCLK_IDLE;
      din_q     <= 1'b0;
      cs_n_q    <= CS_N_IDLE;
      done_q    <= 1'b0;
      dout_s1_q <= 1'b0;
      dout_s2_q <= 1'b0;
    end else if (clk_en) begin
      sh_q      <= sh_d;
      tm_q      <= tm_d;
      bits_q    <= bits_d;
      sreg_q    <= sreg_d;
      sh_size_q <= sh_size_d;
      sh_hold_q <= sh_hold_d;
      sclk_q    <= sclk_d;
      din_q     <= din_d;
      cs_n_q    <= cs_n_d;
      done_q    <= done_d;
      dout_s1_q <= adc_dout;
      dout_s2_q <= dout_s1_q;
    end
  end

  // all outputs straight from flip-flops
  assign adc_sclk       = sclk_q;
  assign adc_din        = din_q;
  assign adc_cs_n       = cs_n_q;
  assign sram_addr      = addr_q;
  assign sram_data      = data_q;
  assign sram_we_n      = we_n_q;
  assign host_bus_grant = grant_q;

endmodule // adc_seq

// ### adc_seq_pkg.sv
/*
  constants and state types for the converter init and capture sequencer.
  assumes a 40 mhz system clock; the serial clock is divided down from it.
*/
package adc_seq_pkg;

  // system clock rate
  localparam int CLK_HZ        = 40_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

  // serial clock half period and chip select idle gap, in ns
  localparam int SCLK_HALF_NS  = 100;
  localparam int CS_GAP_NS     = 100;
  // least times round up to whole cycles; a time of zero gives zero cycles
  localparam int SCLK_HALF_CYC =
    (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_GAP_CYC    =
    (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // transfer sizes
  localparam int TX_BITS       = 8;
  localparam int RX_BITS       = 16;

  // transfer size flag values
  localparam logic SIZE_BYTE_OUT = 1'b0;
  localparam logic SIZE_WORD_IN  = 1'b1;

  // documented defaults
  localparam int NUM_REGS_DEF  = 10;
  localparam int NUM_CHAN_DEF  = 8;
  localparam int ADDR_W_DEF    = 23;

  // idle levels of the serial pins and memory strobe
  localparam logic SCLK_IDLE   = 1'b0;
  localparam logic CS_N_IDLE   = 1'b1;
  localparam logic WE_N_IDLE   = 1'b1;

  // sequencer states, gray along the usual path
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR_SEND = 4'h1,
    ST_ADDR_WAIT = 4'h3,
    ST_DATA_SEND = 4'h2,
    ST_DATA_WAIT = 4'h6,
    ST_CMD_SEND  = 4'h7,
    ST_CMD_WAIT  = 4'h5,
    ST_RX_START  = 4'h4,
    ST_RX_WAIT   = 4'hC,
    ST_FINISHED  = 4'hD
  } seq_state_t;

  // shifter states
  typedef enum logic [1:0] {
    SH_IDLE = 2'h0,
    SH_LOW  = 2'h1,
    SH_HIGH = 2'h3,
    SH_GAP  = 2'h2
  } sh_state_t;

endpackage

// ### adc_seq_props.sv
/*
  port checker for the converter init and capture sequencer.
  assumes clk_en stays high whenever the link or the memory is busy.
*/
`timescale 1ns/1ps
module adc_seq_props #(
  parameter int ADDR_W = adc_seq_pkg::ADDR_W_DEF
) (
  input wire logic              clk_sys,
  input wire logic              reset,
  input wire logic              adc_sclk,
  input wire logic              adc_din,
  input wire logic              adc_cs_n,
  input wire logic [ADDR_W-1:0] sram_addr,
  input wire logic [15:0]       sram_data,
  input wire logic              sram_we_n,
  input wire logic              host_bus_grant
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // the gap resyncs the converter's edge counter, so it must not shrink
  sequence s_gap; adc_cs_n [*4]; endsequence
  sequence s_pulse; !sram_we_n ##1 sram_we_n; endsequence
  sequence s_high; adc_sclk [*4] ##1 !adc_sclk; endsequence

  property p_gap; $rose(adc_cs_n) |-> s_gap; endproperty
  property p_pulse; $fell(sram_we_n) |-> s_pulse; endproperty
  // address settles before the strobe, data stays through its release
  property p_keep;
    $fell(sram_we_n) |-> $stable(sram_addr) ##1 $stable(sram_data);
  endproperty
  property p_store; $fell(sram_we_n) |-> adc_cs_n && $past(adc_cs_n, 3);
  endproperty
  property p_hold; adc_sclk && $past(adc_sclk) |-> $stable(adc_din);
  endproperty
  property p_half; $rose(adc_sclk) |-> s_high; endproperty
  property p_frame; adc_sclk |-> !adc_cs_n; endproperty
  property p_grant;
    host_bus_grant |-> adc_cs_n && sram_we_n && !adc_sclk;
  endproperty
  property p_stay; host_bus_grant |=> host_bus_grant; endproperty

  a_gap: assert property (p_gap) else $error("cs gap short");
  a_pulse: assert property (p_pulse) else $error("we pulse width");
  a_keep: assert property (p_keep) else $error("store not held");
  a_store: assert property (p_store) else $error("store in frame");
  a_hold: assert property (p_hold) else $error("din moved high");
  a_half: assert property (p_half) else $error("sclk high width");
  a_frame: assert property (p_frame) else $error("sclk outside cs");
  a_grant: assert property (p_grant) else $error("link busy granted");
  a_stay: assert property (p_stay) else $error("grant dropped");
endmodule // adc_seq_props

bind adc_seq adc_seq_props #(.ADDR_W(ADDR_W)) u_props (
  .clk_sys       (clk_sys),
  .reset         (reset),
  .adc_sclk      (adc_sclk),
  .adc_din       (adc_din),
  .adc_cs_n      (adc_cs_n),
  .sram_addr     (sram_addr),
  .sram_data     (sram_data),
  .sram_we_n     (sram_we_n),
  .host_bus_grant(host_bus_grant)
);

// ### adc_conv_model.sv
/*
  converter and static memory model on the far side of the sequencer.
  assumes readback starts on the edge after the eighth command bit.
*/
`timescale 1ns/1ps
module adc_conv_model #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              adc_sclk,
  input  wire logic              adc_din,
  input  wire logic              adc_cs_n,
  input  wire logic [ADDR_W-1:0] sram_addr,
  input  wire logic [15:0]       sram_data,
  input  wire logic              sram_we_n,
  output logic                   adc_dout
);
  logic [7:0]         shift_q;
  logic [7:0]         cmd_q;
  logic [15:0]        word_q;
  int                 bits   = 0;
  int                 frames = 0;
  logic [8:0]         link_log[$];
  logic [15:0]        word_log[$];
  logic [ADDR_W+15:0] mem_log[$];
  logic               dout_q = 1'b0;

  assign adc_dout = dout_q;

  // bits latched on the rising edge, result follows the command; a frame
  // close logs it and restarts the edge counter, the line then wanders
  always @(posedge adc_sclk or posedge adc_cs_n) begin
    if (adc_cs_n) begin
      link_log.push_back({bits == 24, cmd_q});
      if (bits == 24)
        word_log.push_back(word_q);
      bits = 0;
      dout_q = ~dout_q;
    end else begin
      shift_q = {shift_q[6:0], adc_din};
      bits++;
      if (bits == 8) begin
        cmd_q = shift_q;
        frames++;
        word_q = {frames[11:0] ^ 12'h5a3, 3'b000, frames[0]};
      end
      if (bits >= 9 && bits <= 24)
        dout_q = word_q[24-bits];
      else
        dout_q = ~dout_q;
    end
  end

  // memory takes one word per strobe, looked at mid-cycle once settled
  always @(negedge clk_sys)
    if (!sram_we_n) mem_log.push_back({sram_addr, sram_data});
endmodule // adc_conv_model

// ### adc_seq_tb.sv
/*
  self-checking bench for the sequencer with converter and memory model.
  assumes the model logs every frame, result word and memory write.
*/
`timescale 1ns/1ps
module adc_seq_tb;
  localparam int NR = 4;
  localparam int NC = 3;
  localparam int AW = 8;
  logic             clk_sys      = 1'b0;
  logic             reset        = 1'b1;
  logic             clk_en       = 1'b1;
  logic [NR-1:0]    cfg_reg_en   = '0;
  logic [NR*8-1:0]  cfg_reg_data = '0;
  logic [NC-1:0]    chan_en      = '0;
  logic [NC*8-1:0]  chan_cmd     = '0;
  logic [NC*AW-1:0] chan_base    = '0;
  logic [NC*AW-1:0] chan_high    = '0;
  logic             adc_dout;
  logic             adc_sclk;
  logic             adc_din;
  logic             adc_cs_n;
  logic             sram_we_n;
  logic             host_bus_grant;
  logic [AW-1:0]    sram_addr;
  logic [15:0]      sram_data;
  logic [31:0]      seed         = 32'd97209;
  int               num_errors   = 0;
  int               comparisons  = 0;

  always #12.5 clk_sys = ~clk_sys;

  adc_seq #(.NUM_REGS(NR), .NUM_CHAN(NC), .ADDR_W(AW)) u_dut (
    .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
    .cfg_reg_en(cfg_reg_en), .cfg_reg_data(cfg_reg_data),
    .chan_en(chan_en), .chan_cmd(chan_cmd), .chan_base(chan_base),
    .chan_high(chan_high), .adc_dout(adc_dout), .adc_sclk(adc_sclk),
    .adc_din(adc_din), .adc_cs_n(adc_cs_n), .sram_addr(sram_addr),
    .sram_data(sram_data), .sram_we_n(sram_we_n),
    .host_bus_grant(host_bus_grant)
  );

  adc_conv_model #(.ADDR_W(AW)) u_adc (
    .clk_sys(clk_sys), .adc_sclk(adc_sclk), .adc_din(adc_din),
    .adc_cs_n(adc_cs_n), .sram_addr(sram_addr), .sram_data(sram_data),
    .sram_we_n(sram_we_n), .adc_dout(adc_dout)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected link log entry: readback flag above the byte sent
  function automatic logic [8:0] frame_exp(input bit         rx,
                                           input logic [7:0] b);
    return {rx, b};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // mode 0 all on with one word per channel, 3 all off, else random
  task automatic run(input int mode, input bit abort);
    int n;
    int k;
    logic [AW-1:0] a;
    @(negedge clk_sys);
    reset = 1'b1;
    cfg_reg_en = (mode == 0) ? '1 : (mode == 3) ? '0 : NR'(rnd());
    chan_en = (mode == 0) ? '1 : (mode == 3) ? '0 : NC'(rnd());
    cfg_reg_data = rnd();
    chan_cmd = 24'(rnd());
    for (int c = 0; c < NC; c++) begin
      a = AW'(rnd() % 200);
      chan_base[c*AW +: AW] = a;
      chan_high[c*AW +: AW] = (mode == 0) ? a : a + AW'(rnd() % 4);
    end
    repeat (5) @(negedge clk_sys);
    check({adc_sclk, adc_din, adc_cs_n, sram_we_n, host_bus_grant,
      sram_addr, sram_data}, {5'b0_0110, 24'h00_0000});
    u_adc.link_log.delete();
    u_adc.word_log.delete();
    u_adc.mem_log.delete();
    clk_en = (mode != 3);
    reset = 1'b0;
    // a frozen clock enable must hold the sequencer still
    repeat (20) @(negedge clk_sys);
    check(host_bus_grant, 1'b0);
    clk_en = 1'b1;
    if (abort) begin
      repeat (400) @(negedge clk_sys);
      return;
    end
    n = 0;
    while (host_bus_grant !== 1'b1 && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    // a hang counts once and the remaining runs still end in results
    if (n == 20000) begin
      num_errors++;
      return;
    end
    repeat (300) @(negedge clk_sys);
    k = 0;
    for (int i = 0; i < NR; i++) begin
      if (cfg_reg_en[i]) begin
        check(u_adc.link_log[k], frame_exp(1'b0, 8'(i)));
        check(u_adc.link_log[k+1],
          frame_exp(1'b0, cfg_reg_data[i*8 +: 8]));
        k += 2;
      end
    end
    n = 0;
    for (int c = 0; c < NC; c++) begin
      if (chan_en[c]) begin
        a = chan_base[c*AW +: AW];
        for (int j = 0; j <= int'(chan_high[c*AW +: AW] - a); j++) begin
          check(u_adc.link_log[k],
            frame_exp(1'b1, chan_cmd[c*8 +: 8]));
          check(u_adc.mem_log[n], {a + AW'(j), u_adc.word_log[n]});
          k++;
          n++;
        end
      end
    end
    check(u_adc.link_log.size(), k);
    check(u_adc.mem_log.size(), n);
  endtask

  initial begin
    run(1, 1'b1);
    for (int m = 0; m < 4; m++)
      run(m, 1'b0);
    results();
  end
endmodule // adc_seq_tb
